/* bench/svsp_host.sv */
// host sequence controller model: drives the output image and runs commands
// assumes the device clock and completion bits in input image word 7
`timescale 1ns/10ps
`default_nettype none
`include "svsp_cfg.svh"
module svsp_host import svsp_pkg::*; (
    input wire logic clk_i,
    input wire svsp_iimg_t iimg_i,
    output var svsp_qimg_t qimg_o
);
    initial qimg_o = '0;
    // ********
    // speed limit word and command handshake
    // ********
    task automatic set_w12(input logic [15:0] v);
        @(posedge clk_i);
        qimg_o.qw12 <= v;
    endtask
    // n and m count edges until completion is seen high, then low
    task automatic cmd(input logic rd, input logic [15:0] w14, input logic [31:0] d8,
            input logic [31:0] d10, input logic [15:0] w12, output int n, output int m);
        int b;
        b = rd ? `SVSP_RD_BIT : `SVSP_WR_BIT;
        @(posedge clk_i);
        qimg_o.qd8 <= d8;
        qimg_o.qd10 <= d10;
        qimg_o.qw12 <= w12;
        qimg_o.qw14 <= w14;
        qimg_o.qw15 <= rd ? 16'h0001 : 16'h0002;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (iimg_i.iw7[b] !== 1'b1 && n < 16);
        qimg_o.qw15 <= 16'h0000;
        // data words may change once completion is seen
        qimg_o.qd8 <= ~d8;
        qimg_o.qd10 <= ~d10;
        m = 0;
        do begin
            @(posedge clk_i);
            m++;
        end while (iimg_i.iw7[b] !== 1'b0 && m < 16);
    endtask
endmodule
`default_nettype wire

/* bench/svsp_top_tb.sv */
// self-checking bench: status flags, registers and image command handshakes
// assumes svsp_host as the partner on the image and one 250 MHz clock
`timescale 1ns/10ps
`default_nettype none
`include "svsp_cfg.svh"
module svsp_top_tb import svsp_pkg::*; ;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [4:0] adr_i = 5'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic ack_o;
    svsp_pins_t pins_i = 7'h63;
    logic [15:0] speed_i = 16'h0010;
    logic [31:0] deviation_i = 32'h0;
    svsp_qimg_t qimg;
    svsp_iimg_t iimg;
    logic ready_o, srdy_o, inp_o, slim_o, alarm_o;
    int err_total = 0;
    int samples_checked = 0;
    int seed = 32'hd2be;
    logic [31:0] pv [16];
    logic [15:0] pm = 16'h0;
    logic [31:0] e8 [4];
    logic [31:0] e10 [4];
    logic [15:0] e12 [4];
    logic [7:0] es [4];
    logic [36:0] reg_tab [7] = '{{5'h00, 32'h0}, {5'h08, 32'h1000}, {5'h0c, 32'h1000},
        {5'h10, 32'h32}, {5'h14, 32'h64}, {5'h18, 32'hfa}, {5'h1c, 32'h0}};
    logic [7:0] alm_tab [5] = '{{7'h6b, 1'b1}, {7'h6f, 1'b1}, {7'h63, 1'b1},
        {7'h67, 1'b0}, {7'h63, 1'b0}};
    logic [26:0] lim_tab [9] = '{{10'h002, 16'h1000, 1'b1}, {10'h002, 16'h0fff, 1'b0},
        {10'h002, 16'hf000, 1'b1}, {10'h004, 16'h0800, 1'b1}, {10'h004, 16'h07ff, 1'b0},
        {10'h064, 16'h0200, 1'b1}, {10'h064, 16'h01ff, 1'b0}, {10'h000, 16'h1000, 1'b1},
        {10'h010, 16'h1000, 1'b0}};
    logic [49:0] inp_tab [11] = '{{7'h63, 10'h002, 32'h1000, 1'b1},
        {7'h63, 10'h004, 32'h1000, 1'b1}, {7'h63, 10'h028, 32'h0, 1'b0},
        {7'h63, 10'h080, 32'h1000, 1'b1}, {7'h63, 10'h100, 32'h1000, 1'b1},
        {7'h63, 10'h200, 32'h1000, 1'b1}, {7'h23, 10'h000, 32'h1000, 1'b1},
        {7'h43, 10'h000, 32'h1000, 1'b1}, {7'h63, 10'h000, 32'h64, 1'b1},
        {7'h63, 10'h000, 32'h65, 1'b0}, {7'h63, 10'h000, 32'hffff_ff9c, 1'b1}};
    always #2 clk_i = ~clk_i;
    svsp_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .pins_i(pins_i), .speed_i(speed_i), .deviation_i(deviation_i), .qimg_i(qimg),
        .iimg_o(iimg), .ready_o(ready_o), .servo_ctrl_ready_o(srdy_o),
        .in_position_flag_o(inp_o), .speed_limit_o(slim_o), .alarm_o(alarm_o));
    svsp_host i_host (.clk_i(clk_i), .iimg_i(iimg), .qimg_o(qimg));
    // ********
    // helpers
    // ********
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string s);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("FAIL %0t %s got %h exp %h", $time, s, g, e);
        end
    endtask
    task automatic w(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask
    task automatic wb(input logic wr, input logic [4:0] a, input logic [31:0] d,
            output logic [31:0] q);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= wr;
        adr_i <= a;
        sel_i <= 4'hf;
        dat_i <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 32);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        chk(32'(n < 32), 32'h1, "bus answer");
    endtask
    task automatic pin(input svsp_pins_t p);
        @(posedge clk_i);
        pins_i <= p;
        w(5);
    endtask
    task automatic dv(input logic [31:0] v, input int k);
        @(posedge clk_i);
        deviation_i <= v;
        w(k);
    endtask
    task automatic hs(input int n, input int m);
        chk(32'(n), 32'h3, "completion delay");
        chk(32'(m < 4), 32'h1, "completion clear");
    endtask
    function automatic logic rdy(input svsp_pins_t p);
        return p.forced_stop_in & !p.free_run_in & p.cpu_ok & p.power_ok;
    endfunction
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #100000;
        err_total++;
        $display("FAIL %0t watchdog", $time);
        print_verdict();
    end
    // ********
    // main sequence
    // ********
    initial begin
        logic [31:0] q;
        logic [3:0] x;
        svsp_pins_t p;
        int n, m;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        chk(32'(inp_o), 32'h1, "inp at reset");
        chk(32'(ready_o), 32'h0, "ready at reset");
        foreach (reg_tab[i]) begin
            wb(1'b0, reg_tab[i][36:32], 32'h0, q);
            chk(q, reg_tab[i][31:0], "register reset");
        end
        wb(1'b1, 5'h1c, 32'hffff_ffff, q);
        wb(1'b0, 5'h1c, 32'h0, q);
        chk(q, 32'h0, "unmapped");
        wb(1'b1, `SVSP_A_STAT, 32'hffff_ffff, q);
        wb(1'b0, `SVSP_A_STAT, 32'h0, q);
        chk(q, 32'h0000_0007, "status word");
        $display("test registers done");
        for (int i = 0; i < 24; i++) begin
            p = (i == 0) ? 7'h63 : 7'($random(seed)) & 7'h73;
            pin(p);
            chk(32'(ready_o), 32'(rdy(p) & p.servo_on), "ready");
            chk(32'(srdy_o), 32'(rdy(p)), "control ready");
        end
        foreach (alm_tab[i]) begin
            pin(svsp_pins_t'(alm_tab[i][7:1]));
            chk(32'(alarm_o), 32'(alm_tab[i][0]), "alarm latch");
            chk(32'(ready_o), 32'(!alm_tab[i][0]), "ready on alarm");
            chk(32'(inp_o), 32'(!alm_tab[i][0]), "inp on alarm");
        end
        $display("test ready and alarm done");
        wb(1'b1, `SVSP_A_TRQSPD, 32'h0800, q);
        i_host.set_w12(16'h0200);
        foreach (lim_tab[i]) begin
            wb(1'b1, `SVSP_A_CTRL, 32'(lim_tab[i][26:17]), q);
            @(posedge clk_i);
            speed_i <= lim_tab[i][16:1];
            w(5);
            chk(32'(slim_o), 32'(lim_tab[i][0]), "speed limit");
        end
        @(posedge clk_i);
        speed_i <= 16'h0010;
        $display("test speed limit done");
        foreach (inp_tab[i]) begin
            wb(1'b1, `SVSP_A_CTRL, 32'(inp_tab[i][42:33]), q);
            @(posedge clk_i);
            pins_i <= inp_tab[i][49:43];
            deviation_i <= inp_tab[i][32:1];
            w(5);
            chk(32'(inp_o), 32'(inp_tab[i][0]), "in position");
        end
        wb(1'b1, `SVSP_A_SHOT, 32'h5, q);
        wb(1'b1, `SVSP_A_CTRL, 32'h1, q);
        dv(32'h1000, 5);
        chk(32'(inp_o), 32'h0, "shot idle");
        dv(32'h0, 0);
        n = 0;
        repeat (24) begin
            @(posedge clk_i);
            if (inp_o === 1'b1) n++;
        end
        chk(32'(n), 32'h5, "shot width");
        wb(1'b1, `SVSP_A_SHOT, 32'h1e, q);
        dv(32'h1000, 5);
        dv(32'h0, 8);
        chk(32'(inp_o), 32'h1, "shot on");
        dv(32'h1000, 4);
        chk(32'(inp_o), 32'h0, "shot early drop");
        $display("test in position done");
        for (int i = 0; i < 12; i++) begin
            x = 4'($random(seed));
            q = $random(seed);
            i_host.cmd(1'b0, {6'h00, x[3:2], 6'h00, x[1:0]}, q, ~q, 16'h0, n, m);
            hs(n, m);
            pv[x] = q;
            pm[x] = 1'b1;
        end
        for (int i = 0; i < 16; i++) begin
            x = 4'(i);
            if (pm[x]) begin
                i_host.cmd(1'b1, {6'h00, x[3:2], 6'h00, x[1:0]}, 32'h0, 32'h0, 16'h0, n, m);
                hs(n, m);
                chk(iimg.id0, pv[x], "parameter read");
            end
        end
        for (int e = 0; e < 4; e++) begin
            es[e] = {4'($random(seed)), `SVSP_BANK_POS};
            e8[e] = $random(seed);
            e10[e] = $random(seed);
            e12[e] = 16'($random(seed));
            i_host.cmd(1'b0, {es[e], 5'h00, 3'(e)}, e8[e], e10[e], e12[e], n, m);
            hs(n, m);
        end
        for (int e = 0; e < 4; e++) begin
            i_host.cmd(1'b1, {4'h0, `SVSP_BANK_POS, 5'h00, 3'(e)}, 32'h0, 32'h0, 16'h0, n, m);
            hs(n, m);
            chk(iimg.id0, e8[e], "entry position");
            chk(iimg.id2, e10[e], "entry speed");
            chk(32'(iimg.iw12), 32'(e12[e]), "entry dwell");
            chk(32'(iimg.iw5[15:8]), 32'(es[e]), "entry status");
        end
        $display("test image commands done");
        print_verdict();
    end
endmodule
`default_nettype wire

/* logic/svsp_top.sv */
// servo status flags and io image parameter access, wishbone register slave
// assumes pins_i comes from outside the clock domain; the rest is synchronous
//
// Local design decisions: register access over Wishbone and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "svsp_cfg.svh"
// Function
// - ready needs servo on, forced stop on, free run off, no alarm, control ready.
// - control ready needs forced stop, no free run, no alarm, cpu and power good.
// - position control holds in-position on in stop states, off on alarm.
// - network variant in position command mode keeps in-position off.
// - speed or torque control keeps in-position on.
// - format 0 is level, 1 single shot; power-on value on for level.
// - level format: in-position while speed and deviation are within range.
// - single shot: pulse for set time, dropped early when deviation leaves range.
// - speed limit output while motor speed reaches the applicable limit.
// - speed and position use max rotation speed, torque uses torque maximum.
// - torque limit select 1 takes the limit from image output word 12.
// - positioning variant position control uses max rotation speed except pulse mode.
// - write command stores double word 8 into bank and number addressed parameter.
// - write completion clears when the write command goes off.
// - read command loads addressed parameter to input double word 0, then completes.
// - read data valid once read completion on; clears when command off.
// - positioning write stores position, speed, dwell and status under the entry number.
// - positioning read returns position, speed, dwell and status in the image.
// - completion bits at input word 7, commands at output word 15.
// - alarm latches; clears on alarm reset rising edge once cause has gone.
module svsp_top import svsp_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [4:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire svsp_pins_t pins_i,
    input wire logic [15:0] speed_i,
    input wire logic [31:0] deviation_i,
    input wire svsp_qimg_t qimg_i,
    output svsp_iimg_t iimg_o,
    output logic ready_o,
    output logic servo_ctrl_ready_o,
    output logic in_position_flag_o,
    output logic speed_limit_o,
    output logic alarm_o
);
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] mag(input logic [31:0] v);
        mag = v[31] ? (~v + 32'h1) : v;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                          input logic [3:0] s);
        merge = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                merge[8*i +: 8] = d[8*i +: 8];
            end
        end
    endfunction

    function automatic logic [3:0] pidx(input logic [15:0] w);
        pidx = {w[`SVSP_BANK_LO +: `SVSP_PBANK_W], w[`SVSP_PNUM_W-1:0]};
    endfunction

    function automatic logic [31:0] rdreg(input logic [4:0] a, input svsp_state_t s);
        case (a)
            `SVSP_A_CTRL: rdreg = {22'h0, s.ctrl};
            `SVSP_A_STAT: rdreg = {25'h0, s.alarm, s.rd_done, s.wr_done, s.slim, s.inp,
                                   s.srdy, s.ready};
            `SVSP_A_MAXSPD: rdreg = {16'h0, s.maxspd};
            `SVSP_A_TRQSPD: rdreg = {16'h0, s.trqspd};
            `SVSP_A_ZSPD: rdreg = {16'h0, s.zspd};
            `SVSP_A_INPR: rdreg = s.inpr;
            `SVSP_A_SHOT: rdreg = {16'h0, s.shot};
            default: rdreg = 32'h0;
        endcase
    endfunction

    svsp_state_t q;
    svsp_state_t n;
    svsp_mode_t mode;
    logic is_pos;
    logic is_trq;
    logic [31:0] spd_abs;
    logic [31:0] dev_abs;
    logic [31:0] lim;
    logic spd_ok;
    logic dev_ok;
    logic cond;
    logic hold;
    logic norm;
    logic fmt;
    logic wcmd;
    logic rcmd;
    logic psel;
    logic req;
    logic rst_rise;
    logic srdy_c;
    logic [31:0] wv;
    logic [`SVSP_POS_AW-1:0] pnum;

    // ****************************************
    // decoded conditions
    // ****************************************
    assign mode = svsp_mode_t'(q.ctrl[`SVSP_B_MODE +: 2]);
    assign is_trq = (mode == SVSP_TRQ);
    assign is_pos = (mode != SVSP_SPD) && !is_trq;
    assign fmt = q.ctrl[`SVSP_B_FMT];
    assign spd_abs = mag({{16{speed_i[15]}}, speed_i});
    assign dev_abs = mag(deviation_i);
    assign spd_ok = spd_abs <= {16'h0, q.zspd};
    assign dev_ok = dev_abs <= q.inpr;
    assign cond = spd_ok && dev_ok;
    // stop states where the flag is held on
    assign hold = !q.s2.servo_on || q.s2.free_run_in || !q.s2.forced_stop_in
                  || q.ctrl[`SVSP_B_LOCK] || q.ctrl[`SVSP_B_OT] || q.ctrl[`SVSP_B_DCLR];
    assign norm = is_pos && !(q.ctrl[`SVSP_B_NET] && q.ctrl[`SVSP_B_PCMD]) && !q.alarm
                  && !hold;
    assign wcmd = qimg_i.qw15[`SVSP_WR_BIT];
    assign rcmd = qimg_i.qw15[`SVSP_RD_BIT];
    assign psel = qimg_i.qw14[`SVSP_BANK_LO +: `SVSP_BANK_W] == `SVSP_BANK_POS;
    assign pnum = qimg_i.qw14[`SVSP_POS_AW-1:0];
    assign req = cyc_i && stb_i;
    assign rst_rise = q.s2.alarm_reset && !q.rst_prev;
    assign wv = merge(rdreg(adr_i, q), dat_i, sel_i);
    assign srdy_c = q.s2.forced_stop_in && !q.s2.free_run_in && !q.alarm
                    && q.s2.cpu_ok && q.s2.power_ok;

    always_comb begin
        // the stored maximum applies unless torque control picks another limit
        lim = {16'h0, q.maxspd};
        if (is_trq) begin
            lim = q.ctrl[`SVSP_B_TSEL] ? {16'h0, qimg_i.qw12} : {16'h0, q.trqspd};
        end
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        n = q;
        n.s1 = pins_i;
        n.s2 = q.s1;
        n.rst_prev = q.s2.alarm_reset;
        if (rst_rise && !q.s2.alarm_cause) begin
            n.alarm = 1'b0;
        end
        if (q.s2.alarm_cause) begin
            n.alarm = 1'b1;
        end
        n.srdy = srdy_c;
        n.ready = q.s2.servo_on && q.s2.forced_stop_in && !q.s2.free_run_in && !q.alarm
                  && srdy_c;
        n.cond_prev = cond;
        if (!is_pos) begin
            n.inp = 1'b1;
            n.cnt = 16'h0;
        end else if (q.ctrl[`SVSP_B_NET] && q.ctrl[`SVSP_B_PCMD]) begin
            n.inp = 1'b0;
            n.cnt = 16'h0;
        end else if (q.alarm) begin
            n.inp = 1'b0;
            n.cnt = 16'h0;
        end else if (hold) begin
            n.inp = 1'b1;
            n.cnt = 16'h0;
        end else if (!fmt) begin
            n.inp = cond;
            n.cnt = 16'h0;
        end else if (q.inp) begin
            if (!dev_ok || q.cnt <= 16'h1) begin
                n.inp = 1'b0;
                n.cnt = 16'h0;
            end else begin
                n.cnt = q.cnt - 16'h1;
            end
        end else if (cond && !q.cond_prev) begin
            n.inp = 1'b1;
            n.cnt = q.shot;
        end
        // no detection in pulse operation under position control
        n.slim = !(is_pos && q.ctrl[`SVSP_B_PULSE]) && (spd_abs >= lim);
        unique case (q.hs)
            SVSP_HS_IDLE: begin
                if (wcmd && !q.wr_done) begin
                    n.hs = SVSP_HS_EXEC;
                    n.op_rd = 1'b0;
                end else if (rcmd && !q.rd_done) begin
                    n.hs = SVSP_HS_EXEC;
                    n.op_rd = 1'b1;
                end
            end
            SVSP_HS_EXEC: begin
                n.hs = SVSP_HS_WAIT;
                if (!q.op_rd) begin
                    if (psel) begin
                        n.ppos[pnum] = qimg_i.qd8;
                        n.pspd[pnum] = qimg_i.qd10;
                        n.pdwell[pnum] = qimg_i.qw12;
                        n.pstat[pnum] = qimg_i.qw14[15:8];
                    end else begin
                        n.par[pidx(qimg_i.qw14)] = qimg_i.qd8;
                    end
                    n.wr_done = 1'b1;
                end else begin
                    if (psel) begin
                        n.img.id0 = q.ppos[pnum];
                        n.img.id2 = q.pspd[pnum];
                        n.img.iw12 = q.pdwell[pnum];
                        n.img.iw5 = {q.pstat[pnum], 8'h00};
                    end else begin
                        n.img.id0 = q.par[pidx(qimg_i.qw14)];
                    end
                    n.rd_done = 1'b1;
                end
            end
            SVSP_HS_WAIT: begin
                if (q.op_rd ? !rcmd : !wcmd) begin
                    n.hs = SVSP_HS_IDLE;
                    n.wr_done = 1'b0;
                    n.rd_done = 1'b0;
                end
            end
            default: n.hs = SVSP_HS_IDLE;
        endcase
        n.img.iw7 = 16'h0;
        n.img.iw7[`SVSP_WR_BIT] = n.wr_done;
        n.img.iw7[`SVSP_RD_BIT] = n.rd_done;
        // wishbone: ack one cycle after the request, write on the acked edge
        n.ack = req && !q.ack;
        if (req && !q.ack) begin
            n.dat = rdreg(adr_i, q);
        end
        if (req && q.ack && we_i) begin
            unique case (adr_i)
                `SVSP_A_CTRL: n.ctrl = wv[`SVSP_CTRL_W-1:0];
                `SVSP_A_MAXSPD: n.maxspd = wv[15:0];
                `SVSP_A_TRQSPD: n.trqspd = wv[15:0];
                `SVSP_A_ZSPD: n.zspd = wv[15:0];
                `SVSP_A_INPR: n.inpr = wv;
                `SVSP_A_SHOT: n.shot = wv[15:0];
                default: n.ctrl = q.ctrl;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // stores, image and all flags but in-position clear; in-position and settings take their defaults
            q <= '0;
            q.hs <= SVSP_HS_IDLE;
            q.ctrl <= `SVSP_CTRL_RST;
            q.inp <= `SVSP_INP_RST;
            q.maxspd <= `SVSP_MAXSPD_RST;
            q.trqspd <= `SVSP_TRQSPD_RST;
            q.zspd <= `SVSP_ZSPD_RST;
            q.inpr <= `SVSP_INPR_RST;
            q.shot <= `SVSP_SHOT_RST;
        end else begin
            q <= n;
        end
    end

    assign dat_o = q.dat;
    assign ack_o = q.ack;
    assign iimg_o = q.img;
    assign ready_o = q.ready;
    assign servo_ctrl_ready_o = q.srdy;
    assign in_position_flag_o = q.inp;
    assign speed_limit_o = q.slim;
    assign alarm_o = q.alarm;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_ready_conds: assert property (
        ready_o |-> $past(q.s2.servo_on && q.s2.forced_stop_in && !q.s2.free_run_in
        && !q.alarm)) else $error("ready without its inputs");
    a_ready_srdy: assert property (ready_o |-> servo_ctrl_ready_o)
        else $error("ready without control ready");
    a_srdy_conds: assert property (
        servo_ctrl_ready_o |-> $past(q.s2.cpu_ok && q.s2.power_ok && !q.alarm))
        else $error("control ready wrongly set");
    a_inp_alarm: assert property ((is_pos && q.alarm) |=> !in_position_flag_o)
        else $error("in-position on during alarm");
    a_inp_netcmd: assert property (
        (is_pos && q.ctrl[`SVSP_B_NET] && q.ctrl[`SVSP_B_PCMD]) |=> !in_position_flag_o)
        else $error("in-position on in command mode");
    a_inp_speed: assert property (!is_pos |=> in_position_flag_o)
        else $error("in-position off outside position control");
    a_inp_level: assert property (
        (norm && !fmt) |=> in_position_flag_o == $past(cond))
        else $error("level in-position mismatch");
    a_shot_early: assert property (
        (norm && fmt && q.inp && !dev_ok) |=> !in_position_flag_o)
        else $error("single shot not dropped");
    a_trq_sel: assert property (
        (is_trq && q.ctrl[`SVSP_B_TSEL] && spd_abs >= {16'h0, qimg_i.qw12})
        |=> speed_limit_o) else $error("image speed limit ignored");
    a_slim_pulse: assert property (
        (is_pos && q.ctrl[`SVSP_B_PULSE]) |=> !speed_limit_o)
        else $error("speed limit flagged in pulse operation");
    a_wr_store: assert property (
        (q.hs == SVSP_HS_EXEC && !q.op_rd && !psel)
        |=> q.par[$past(pidx(qimg_i.qw14))] == $past(qimg_i.qd8) && q.wr_done)
        else $error("parameter write lost");
    a_pos_store: assert property (
        (q.hs == SVSP_HS_EXEC && !q.op_rd && psel)
        |=> q.ppos[$past(pnum)] == $past(qimg_i.qd8) && q.pspd[$past(pnum)] == $past(qimg_i.qd10))
        else $error("entry write lost");
    a_wr_clear: assert property (
        (q.hs == SVSP_HS_WAIT && !q.op_rd && !wcmd) |=> !q.wr_done)
        else $error("write completion stuck");
    a_rd_clear: assert property (
        (q.hs == SVSP_HS_WAIT && q.op_rd && !rcmd) |=> !q.rd_done)
        else $error("read completion stuck");
    a_done_late: assert property (
        $rose(q.wr_done || q.rd_done)
        |-> $past(q.hs, 1) == SVSP_HS_EXEC && $past(q.hs, 2) == SVSP_HS_IDLE)
        else $error("completion too early");
    a_alarm_hold: assert property (
        (q.alarm && !(rst_rise && !q.s2.alarm_cause)) |=> alarm_o)
        else $error("alarm cleared without reset edge");

    // one cover for each main scenario
    c_ready: cover property ($rose(ready_o));
    c_shot: cover property (norm && fmt && $rose(in_position_flag_o));
    c_write: cover property ($rose(q.wr_done));
    c_read_pos: cover property ($rose(q.rd_done) && psel);
    c_alarm_clear: cover property ($fell(alarm_o));
endmodule
`default_nettype wire

/* pkg/svsp_cfg.svh */
// constants for the servo status and parameter access block
// assumes inclusion by its bare name from the package and the top module
`ifndef SVSP_CFG_SVH
`define SVSP_CFG_SVH
// ****************************************
// register byte addresses
// ****************************************
`define SVSP_A_CTRL 5'h00
`define SVSP_A_STAT 5'h04
`define SVSP_A_MAXSPD 5'h08
`define SVSP_A_TRQSPD 5'h0c
`define SVSP_A_ZSPD 5'h10
`define SVSP_A_INPR 5'h14
`define SVSP_A_SHOT 5'h18
// ****************************************
// control field positions and reset values
// ****************************************
`define SVSP_CTRL_W 10
`define SVSP_B_FMT 0
`define SVSP_B_MODE 1
`define SVSP_B_PCMD 3
`define SVSP_B_PULSE 4
`define SVSP_B_NET 5
`define SVSP_B_TSEL 6
`define SVSP_B_LOCK 7
`define SVSP_B_OT 8
`define SVSP_B_DCLR 9
`define SVSP_CTRL_RST 10'h000
`define SVSP_INP_RST 1'b1
`define SVSP_MAXSPD_RST 16'h1000
`define SVSP_TRQSPD_RST 16'h1000
`define SVSP_ZSPD_RST 16'h0032
`define SVSP_INPR_RST 32'h0000_0064
`define SVSP_SHOT_RST 16'h00fa
// ****************************************
// io image layout and stores
// ****************************************
`define SVSP_WR_BIT 1
`define SVSP_RD_BIT 0
`define SVSP_BANK_LO 8
`define SVSP_BANK_W 4
`define SVSP_BANK_POS 4'hf
`define SVSP_PBANK_W 2
`define SVSP_PNUM_W 2
`define SVSP_PAR_N 16
`define SVSP_POS_AW 3
`define SVSP_POS_N 8
`endif

/* pkg/svsp_pkg.sv */
// types for the servo status and parameter access block
// assumes svsp_cfg.svh is on the include path
`include "svsp_cfg.svh"
package svsp_pkg;
    typedef enum logic [1:0] {SVSP_POS, SVSP_SPD, SVSP_TRQ} svsp_mode_t;
    typedef enum logic [1:0] {SVSP_HS_IDLE, SVSP_HS_EXEC, SVSP_HS_WAIT} svsp_hs_t;
    typedef struct packed {
        logic servo_on;
        logic forced_stop_in;
        logic free_run_in;
        logic alarm_cause;
        logic alarm_reset;
        logic cpu_ok;
        logic power_ok;
    } svsp_pins_t;
    typedef struct packed {
        logic [31:0] qd8;
        logic [31:0] qd10;
        logic [15:0] qw12;
        logic [15:0] qw14;
        logic [15:0] qw15;
    } svsp_qimg_t;
    typedef struct packed {
        logic [31:0] id0;
        logic [31:0] id2;
        logic [15:0] iw5;
        logic [15:0] iw7;
        logic [15:0] iw12;
    } svsp_iimg_t;
    typedef struct packed {
        svsp_pins_t s1;
        svsp_pins_t s2;
        logic rst_prev;
        logic alarm;
        logic [`SVSP_CTRL_W-1:0] ctrl;
        logic [15:0] maxspd;
        logic [15:0] trqspd;
        logic [15:0] zspd;
        logic [15:0] shot;
        logic [31:0] inpr;
        logic ack;
        logic [31:0] dat;
        svsp_hs_t hs;
        logic op_rd;
        logic wr_done;
        logic rd_done;
        logic [`SVSP_PAR_N-1:0][31:0] par;
        logic [`SVSP_POS_N-1:0][31:0] ppos;
        logic [`SVSP_POS_N-1:0][31:0] pspd;
        logic [`SVSP_POS_N-1:0][15:0] pdwell;
        logic [`SVSP_POS_N-1:0][7:0] pstat;
        svsp_iimg_t img;
        logic ready;
        logic srdy;
        logic inp;
        logic cond_prev;
        logic slim;
        logic [15:0] cnt;
    } svsp_state_t;
endpackage
